// >>> src/plp_life_counter.sv
`timescale 1ns/1ns
`default_nettype none
module plp_life_counter #(
  parameter int unsigned UNITS = plp_pkg::INRUSH_CLOSURES_PER_PCT,
  parameter int unsigned STEP_W = 4
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Wear units to add this cycle
  input wire logic [STEP_W-1:0] step_in,
  // Remaining life
  output logic [plp_pkg::PCT_W-1:0] life_out
);
  import plp_pkg::*;
  localparam int unsigned ACC_W = $clog2(UNITS) + 1;
  localparam logic [ACC_W:0] UNITS_C = (ACC_W+1)'(UNITS);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [PCT_W-1:0] life;
  } plp_cnt_s;

  plp_cnt_s st_r;
  plp_cnt_s st_nxt;
  logic [ACC_W:0] sum;

  // A step is assumed smaller than one percent worth of units.
  always_comb begin
    st_nxt = st_r;
    sum = {1'b0, st_r.acc} + (ACC_W+1)'(step_in);
    if (sum >= UNITS_C) begin
      st_nxt.acc = ACC_W'(sum - UNITS_C);
      if (st_r.life != '0) begin
        st_nxt.life = st_r.life - PCT_W'(1); // RQ4 RQ18
      end
    end else begin
      st_nxt.acc = sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_r <= '{acc: '0, life: LIFE_FULL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign life_out = st_r.life;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_life_no_wrap: assert property (life_out == '0 |=> life_out == '0) // RQ18
    else $error("life value wrapped below zero");
  a_life_one_step: assert property ( // RQ4
    life_out != $past(life_out) |-> life_out == $past(life_out) - 1'b1)
    else $error("life value moved by other than one percent");
endmodule
`default_nettype wire

// >>> src/plp_out_terminal.sv
`timescale 1ns/1ns
`default_nettype none
module plp_out_terminal (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Function selection and alarm
  input wire logic [7:0] func_code_in,
  input wire logic alarm_in,
  // Terminal level
  output logic term_out
);
  import plp_pkg::*;

  typedef struct packed {
    logic term;
  } plp_term_s;

  plp_term_s st_r;
  plp_term_s st_nxt;

  // Any other code leaves the terminal low, since it belongs elsewhere.
  always_comb begin
    st_nxt.term = 1'b0;
    if (func_code_in == FUNC_ALARM_POS) begin
      st_nxt.term = alarm_in; // RQ3
    end else if (func_code_in == FUNC_ALARM_NEG) begin
      st_nxt.term = !alarm_in; // RQ3
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_r <= '{term: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign term_out = st_r.term;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_term_pos_high: assert property ( // RQ3
    func_code_in == FUNC_ALARM_POS |=> term_out == $past(alarm_in))
    else $error("positive logic terminal does not follow alarm");
  a_term_neg_low: assert property ( // RQ3
    func_code_in == FUNC_ALARM_NEG && alarm_in |=> !term_out)
    else $error("negative logic terminal high during alarm");
endmodule
`default_nettype wire

// >>> src/plp_part_life_monitor.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module plp_part_life_monitor #(
  parameter int unsigned INRUSH_PER_PCT = plp_pkg::INRUSH_CLOSURES_PER_PCT,
  parameter int unsigned CTRL_PER_PCT = plp_pkg::CTRL_UNITS_PER_PCT,
  parameter int unsigned DC_CYCLES_P = plp_pkg::DC_CYCLES,
  parameter bit OPT_CARD = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [plp_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [plp_pkg::DATA_W-1:0] pwdata_in,
  output logic [plp_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Wear sources
  input wire logic inrush_close_in,
  input wire logic age_tick_in,
  input wire logic [plp_pkg::TEMP_W-1:0] temp_weight_in,
  input wire logic fan_slow_in,
  // Drive conditions seen by the capacitor measurement
  input wire logic power_off_in,
  input wire logic run_cmd_in,
  input wire logic output_shutoff_input_in,
  input wire logic trip_in,
  input wire logic cap_ok_in,
  input wire logic [plp_pkg::PCT_W-1:0] cap_pct_in,
  // Motor DC injection
  output logic dc_inject_out,
  // Alarm outputs
  output logic combined_life_alarm_out,
  output logic life_term_out,
  output logic fan_fault_indication_out,
  output logic control_cap_wear_out_out,
  output logic main_cap_wear_out_out,
  output logic fan_wear_out_out,
  output logic inrush_wear_out_out,
  // Interrupt
  output logic irq_out
);
  import plp_pkg::*;

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  localparam logic [DC_W-1:0] DC_LAST = DC_W'(DC_CYCLES_P - 1);

  typedef enum logic [2:0] {
    ms_idle,
    ms_armed,
    ms_meas,
    ms_done,
    ms_forced,
    ms_error
  } plp_meas_e;

  typedef struct packed {
    plp_meas_e meas;
    logic [DC_W-1:0] dc_cnt;
    logic [PCT_W-1:0] main_life;
    logic [3:0] bitmap;
    logic alarm;
    logic [7:0] func_code;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DATA_W-1:0] prdata;
    logic slverr;
  } plp_top_s;

  function automatic logic [3:0] meas_code(input plp_meas_e s);
    logic [3:0] c;
    c = MS_IDLE;
    unique case (s)
      ms_idle: c = MS_IDLE;
      ms_armed: c = MS_ARMED;
      ms_meas: c = MS_MEAS;
      ms_done: c = MS_DONE;
      ms_forced: c = MS_FORCED;
      ms_error: c = MS_ERROR;
    endcase
    return c;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Life counters
  // ----------------------------------------------------------------
  logic [PCT_W-1:0] inrush_life;
  logic [PCT_W-1:0] ctrl_life;
  logic [TEMP_W-1:0] ctrl_step;

  // Hotter ticks weigh more, so the control capacitor ages faster warm.
  assign ctrl_step = (age_tick_in && !power_off_in) ?
                     temp_weight_in : '0; // RQ6

  plp_life_counter #(
    .UNITS(INRUSH_PER_PCT),
    .STEP_W(1)
  ) u_inrush_life (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(inrush_close_in),
    .life_out(inrush_life)
  );

  plp_life_counter #(
    .UNITS(CTRL_PER_PCT),
    .STEP_W(TEMP_W)
  ) u_ctrl_life (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(ctrl_step),
    .life_out(ctrl_life)
  );

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  plp_top_s st_r;
  plp_top_s st_nxt;
  logic wr;
  logic setup;
  logic [3:0] bm;
  logic [3:0] wr_code;
  logic meas_end;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic inrush_low;
  logic ctrl_low;
  logic main_low;

  assign inrush_low = inrush_life <= INRUSH_ALARM_PCT;
  assign ctrl_low = ctrl_life < CTRL_ALARM_PCT;
  assign main_low = st_r.main_life <= MAIN_ALARM_PCT;

  always_comb begin
    st_nxt = st_r;
    wr = psel_in && penable_in && pwrite_in;
    setup = psel_in && !penable_in;
    wr_code = pwdata_in[3:0];
    bm = '0;
    bm[BIT_INRUSH] = inrush_low; // RQ5
    bm[BIT_CTRL] = ctrl_low; // RQ7
    bm[BIT_MAIN] = main_low; // RQ9
    bm[BIT_FAN] = fan_slow_in; // RQ16
    st_nxt.bitmap = bm; // RQ1
    st_nxt.alarm = |st_r.bitmap; // RQ2

    // Capacitor measurement across a power cycle.
    unique case (st_r.meas)
      ms_idle, ms_done, ms_forced, ms_error: begin
        if (wr && hit(paddr_in, ADDR_MEAS)) begin
          if (wr_code == MS_ARMED) begin
            st_nxt.meas = ms_armed; // RQ11
          end else if (wr_code == MS_IDLE) begin
            st_nxt.meas = ms_idle; // RQ10
          end
        end
      end
      ms_armed: begin
        if (power_off_in) begin
          st_nxt.meas = ms_meas; // RQ11
          st_nxt.dc_cnt = '0;
        end else if (wr && hit(paddr_in, ADDR_MEAS) &&
                     wr_code == MS_IDLE) begin
          st_nxt.meas = ms_idle; // RQ10
        end
      end
      ms_meas: begin
        if (trip_in) begin
          st_nxt.meas = ms_error; // RQ14
        end else if (run_cmd_in || output_shutoff_input_in) begin
          st_nxt.meas = ms_forced; // RQ14
        end else if (!power_off_in) begin
          st_nxt.meas = ms_armed; // RQ14
        end else if (st_r.dc_cnt == DC_LAST) begin
          if (cap_ok_in) begin
            st_nxt.meas = ms_done;
            st_nxt.main_life = cap_pct_in; // RQ8
          end else begin
            st_nxt.meas = ms_error;
          end
        end else begin
          st_nxt.dc_cnt = st_r.dc_cnt + DC_W'(1); // RQ12
        end
      end
    endcase

    // A clear never hides an event that lands in the same cycle.
    meas_end = (st_r.meas == ms_meas) &&
               (st_nxt.meas != ms_meas) && (st_nxt.meas != ms_armed);
    irq_set = {meas_end, bm & ~st_r.bitmap};
    irq_clr = '0;
    if (wr && hit(paddr_in, ADDR_IRQ_STAT)) begin
      irq_clr = pwdata_in[IRQ_W-1:0];
    end
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
    if (wr && hit(paddr_in, ADDR_IRQ_MASK)) begin
      st_nxt.irq_mask = pwdata_in[IRQ_W-1:0];
    end
    if (wr && hit(paddr_in, ADDR_FUNC)) begin
      st_nxt.func_code = pwdata_in[7:0];
    end
    st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);

    // Read data is latched in the setup cycle so it leaves a flop.
    if (setup) begin
      st_nxt.slverr = 1'b0;
      case (paddr_in)
        ADDR_BITMAP: st_nxt.prdata = DATA_W'(st_r.bitmap); // RQ1
        ADDR_INRUSH: st_nxt.prdata = DATA_W'(inrush_life);
        ADDR_CTRL: st_nxt.prdata = DATA_W'(ctrl_life);
        ADDR_MAIN: st_nxt.prdata = DATA_W'(st_r.main_life);
        ADDR_MEAS: st_nxt.prdata = DATA_W'(meas_code(st_r.meas));
        ADDR_FUNC: st_nxt.prdata = DATA_W'(st_r.func_code);
        ADDR_IRQ_STAT: st_nxt.prdata = DATA_W'(st_r.irq_stat);
        ADDR_IRQ_MASK: st_nxt.prdata = DATA_W'(st_r.irq_mask);
        default: begin
          st_nxt.prdata = '0;
          st_nxt.slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_r <= '{meas: ms_idle, dc_cnt: '0, main_life: LIFE_FULL,
                bitmap: '0, alarm: 1'b0, func_code: FUNC_RESET,
                irq_stat: '0, irq_mask: '0, irq: 1'b0,
                prdata: '0, slverr: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  plp_out_terminal u_term (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .func_code_in(st_r.func_code),
    .alarm_in(st_r.alarm),
    .term_out(life_term_out)
  );

  assign prdata_out = st_r.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = st_r.slverr;
  assign dc_inject_out = st_r.meas == ms_meas; // RQ12
  assign combined_life_alarm_out = st_r.alarm; // RQ2
  assign fan_fault_indication_out = st_r.bitmap[BIT_FAN]; // RQ16
  assign irq_out = st_r.irq;
  // Without the option card the per-part signals stay low.
  assign control_cap_wear_out_out = OPT_CARD && st_r.bitmap[BIT_CTRL]; // RQ17
  assign main_cap_wear_out_out = OPT_CARD && st_r.bitmap[BIT_MAIN]; // RQ17
  assign fan_wear_out_out = OPT_CARD && st_r.bitmap[BIT_FAN]; // RQ17
  assign inrush_wear_out_out = OPT_CARD && st_r.bitmap[BIT_INRUSH]; // RQ17

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_bitmap_read: assert property ( // RQ1
    setup && paddr_in == ADDR_BITMAP |=>
      prdata_out == DATA_W'($past(st_r.bitmap)))
    else $error("bitmap read returned wrong value");
  a_alarm_any_bit: assert property ( // RQ2
    st_r.bitmap != '0 |=> combined_life_alarm_out)
    else $error("alarm low while a bitmap bit is set");
  a_alarm_clear: assert property ( // RQ2
    st_r.bitmap == '0 |=> !combined_life_alarm_out)
    else $error("alarm high with an empty bitmap");
  a_inrush_bit: assert property ( // RQ5
    inrush_low |=> st_r.bitmap[BIT_INRUSH])
    else $error("inrush bit missing at ten percent");
  a_ctrl_bit: assert property ( // RQ7
    st_r.bitmap[BIT_CTRL] == $past(ctrl_low))
    else $error("control capacitor bit disagrees with life");
  a_main_bit: assert property ( // RQ9
    main_low |=> st_r.bitmap[BIT_MAIN])
    else $error("main capacitor bit missing at 85 percent");
  a_fan_chain: assert property ( // RQ16
    fan_slow_in |=> fan_fault_indication_out ##1 combined_life_alarm_out)
    else $error("slow fan did not raise fault and alarm");
  a_arm_start: assert property ( // RQ11
    st_r.meas == ms_armed && power_off_in |=>
      dc_inject_out && st_r.dc_cnt == '0)
    else $error("armed power-down did not start measurement");
  a_no_start_on: assert property ( // RQ11
    st_r.meas == ms_armed && !power_off_in |=> !dc_inject_out)
    else $error("measurement started with supply on");
  a_dc_full_time: assert property ( // RQ12
    $fell(dc_inject_out) && st_r.meas == ms_done |->
      $past(st_r.dc_cnt) == DC_LAST)
    else $error("DC injection did not last its full time");
  a_abort_forced: assert property ( // RQ14
    dc_inject_out && !trip_in && (run_cmd_in || output_shutoff_input_in)
      |=> meas_code(st_r.meas) == MS_FORCED)
    else $error("run or shutoff did not force the end");
  a_trip_error: assert property ( // RQ14
    dc_inject_out && trip_in |=> meas_code(st_r.meas) == MS_ERROR)
    else $error("trip did not end measurement in error");
  a_code_ro: assert property ( // RQ10
    wr && paddr_in == ADDR_MEAS && st_r.meas == ms_idle &&
      wr_code != MS_ARMED |=> st_r.meas == ms_idle)
    else $error("status-only state code was written");
  a_result_load: assert property ( // RQ8
    dc_inject_out && st_nxt.meas == ms_done |=>
      st_r.main_life == $past(cap_pct_in))
    else $error("main capacitor life not updated on completion");
  a_irq_set_wins: assert property (
    irq_set[IRQ_MEAS_END] && irq_clr[IRQ_MEAS_END] |=>
      st_r.irq_stat[IRQ_MEAS_END])
    else $error("clear beat a simultaneous measurement event");
  a_power_back: assert property ( // RQ14
    dc_inject_out && !trip_in && !run_cmd_in &&
      !output_shutoff_input_in && !power_off_in |=> st_r.meas == ms_armed)
    else $error("power return did not re-arm the measurement");
  a_write_disarm: assert property ( // RQ10
    st_r.meas == ms_armed && !power_off_in && wr &&
      paddr_in == ADDR_MEAS && wr_code == MS_IDLE |=> st_r.meas == ms_idle)
    else $error("write of zero did not disarm the measurement");
  a_irq_raise: assert property (
    (st_r.irq_stat & st_r.irq_mask) != '0 |=> irq_out)
    else $error("interrupt low with an unmasked event pending");
  a_irq_quiet: assert property (
    (st_r.irq_stat & st_r.irq_mask) == '0 |=> !irq_out)
    else $error("interrupt high with no unmasked event");
endmodule
`default_nettype wire

// >>> src/plp_pkg.sv
// Functional notes
// RQ1: Read-only 4-bit bitmap; bits 3..0 inrush, fan, main cap, control cap.
// RQ2: Combined life alarm is on whenever any bitmap bit is set.
// RQ3: Terminal code 90 drives the alarm active-high, code 190 active-low.
// RQ4: Count inrush closures; inrush life drops one percent per 10,000.
// RQ5: Inrush life at 10 percent sets bitmap bit 3 and the alarm at once.
// RQ6: Powered, control cap life falls with energized time and temperature.
// RQ7: Control cap life below 10 percent sets bitmap bit 0 and the alarm.
// RQ8: A completed measurement sets main cap life; shipment is 100 percent.
// RQ9: Measured main cap life at or below 85 percent sets bit 1 and alarm.
// RQ10: State codes 0,1,2,3,8,9; codes 2,3,8,9 are status only, never written.
// RQ11: Software arms with 1; supply off while armed starts measuring.
// RQ12: During an armed power-down, DC is applied to the motor for one second.
// RQ13: Software checks the state reads 3 before trusting main cap life.
// RQ14: Run, shutoff, trip or power return end forced, error, or armed.
// RQ15: Operator ensures the motor is connected and stationary before arming.
// RQ16: Fan speed at half or less sets bit 2, alarm and fan fault indication.
// RQ17: With the option card fitted, each part drives its own life signal.
// RQ18: Every life percentage saturates at zero and never wraps.
package plp_pkg;
  // ----------------------------------------------------------------
  // Life values
  // ----------------------------------------------------------------
  localparam int unsigned PCT_W = 7;
  localparam int unsigned TEMP_W = 4;
  localparam logic [PCT_W-1:0] LIFE_FULL = 7'h64;
  localparam logic [PCT_W-1:0] INRUSH_ALARM_PCT = 7'h0a;
  localparam logic [PCT_W-1:0] CTRL_ALARM_PCT = 7'h0a;
  localparam logic [PCT_W-1:0] MAIN_ALARM_PCT = 7'h55;
  localparam int unsigned INRUSH_CLOSURES_PER_PCT = 10000;
  localparam int unsigned CTRL_UNITS_PER_PCT = 3600;
  localparam int unsigned BIT_CTRL = 0;
  localparam int unsigned BIT_MAIN = 1;
  localparam int unsigned BIT_FAN = 2;
  localparam int unsigned BIT_INRUSH = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DC_TIME_MS = 1000;
  localparam int unsigned DC_CYCLES = DC_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DC_W = 32;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MS_IDLE = 4'h0;
  localparam logic [3:0] MS_ARMED = 4'h1;
  localparam logic [3:0] MS_MEAS = 4'h2;
  localparam logic [3:0] MS_DONE = 4'h3;
  localparam logic [3:0] MS_FORCED = 4'h8;
  localparam logic [3:0] MS_ERROR = 4'h9;
  localparam logic [7:0] FUNC_ALARM_POS = 8'h5a;
  localparam logic [7:0] FUNC_ALARM_NEG = 8'hbe;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_BITMAP = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INRUSH = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MAIN = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MEAS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FUNC = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h1c;
  localparam logic [7:0] FUNC_RESET = FUNC_ALARM_POS;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_MEAS_END = 4;
endpackage

// >>> tb/plp_alarm_reader.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Controller reading the alarm terminal
// ----------------------------------------------------------------
module plp_alarm_reader (
  // Clock
  input wire logic ref_clk_in,
  // Terminal and the polarity it was configured for
  input wire logic term_in,
  input wire logic active_low_in,
  // Decoded alarm
  output logic alarm_seen_out
);
  // Registered like a real input stage, so it lags the terminal a cycle.
  always_ff @(posedge ref_clk_in) begin
    alarm_seen_out <= active_low_in ? !term_in : term_in;
  end
endmodule
`default_nettype wire

// >>> tb/tb_part_life_alarm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_part_life_alarm_monitor;
  import plp_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts keep the run to a few thousand cycles.
  // ----------------------------------------------------------------
  localparam int unsigned IN_PER = 4;
  localparam int unsigned CT_PER = 8;
  localparam int unsigned DC_N = 16;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic inrush, age, fan_slow, pwr_off, run, shut, trip, cap_ok;
  logic [TEMP_W-1:0] temp_w;
  logic [PCT_W-1:0] cap_pct;
  logic dc, alarm, term, fan_ind, w_ctrl, w_main, w_fan, w_inr, irq;
  logic seen, act_low;
  int mismatches, tests_run, cycles;
  plp_part_life_monitor #(.INRUSH_PER_PCT(IN_PER), .CTRL_PER_PCT(CT_PER),
    .DC_CYCLES_P(DC_N), .OPT_CARD(1'b1)) dut_u (
    .ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .inrush_close_in(inrush), .age_tick_in(age),
    .temp_weight_in(temp_w), .fan_slow_in(fan_slow),
    .power_off_in(pwr_off), .run_cmd_in(run),
    .output_shutoff_input_in(shut), .trip_in(trip), .cap_ok_in(cap_ok),
    .cap_pct_in(cap_pct), .dc_inject_out(dc),
    .combined_life_alarm_out(alarm), .life_term_out(term),
    .fan_fault_indication_out(fan_ind), .control_cap_wear_out_out(w_ctrl),
    .main_cap_wear_out_out(w_main), .fan_wear_out_out(w_fan),
    .inrush_wear_out_out(w_inr), .irq_out(irq));
  plp_alarm_reader rd_u (.ref_clk_in(clk), .term_in(term),
    .active_low_in(act_low), .alarm_seen_out(seen));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // APB master: request held until pready is seen at an edge.
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic pulses(input int n, input bit ctl);
    repeat (n) begin
      @(posedge clk);
      if (ctl) age <= 1'h1; else inrush <= 1'h1;
      @(posedge clk);
      age <= 1'h0;
      inrush <= 1'h0;
    end
    wt(5);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdchk(ADDR_BITMAP, 32'h0);
    rdchk(ADDR_INRUSH, {25'h0, LIFE_FULL});
    rdchk(ADDR_CTRL, {25'h0, LIFE_FULL});
    rdchk(ADDR_MAIN, {25'h0, LIFE_FULL});
    apb(1'h1, ADDR_MEAS, 32'h2);
    rdchk(ADDR_MEAS, {28'h0, MS_IDLE});
    apb(1'h1, ADDR_BITMAP, 32'hf);
    rdchk(ADDR_BITMAP, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    `CHK(err, 1'h1)
    `CHK(alarm, 1'h0)
  endtask
  task automatic t_fan;
    apb(1'h1, ADDR_IRQ_MASK, 32'h1f);
    fan_slow <= 1'h1;
    wt(6);
    rdchk(ADDR_BITMAP, 32'h4);
    `CHK(alarm, 1'h1)
    `CHK(fan_ind, 1'h1)
    `CHK({w_inr, w_fan, w_main, w_ctrl}, 4'h4)
    `CHK(term, 1'h1)
    `CHK(seen, 1'h1)
    `CHK(irq, 1'h1)
    apb(1'h1, ADDR_FUNC, {24'h0, FUNC_ALARM_NEG});
    act_low <= 1'h1;
    wt(4);
    `CHK(term, 1'h0)
    `CHK(seen, 1'h1)
    apb(1'h1, ADDR_FUNC, 32'h0);
    wt(3);
    `CHK(term, 1'h0)
    apb(1'h1, ADDR_FUNC, {24'h0, FUNC_ALARM_POS});
    act_low <= 1'h0;
    apb(1'h1, ADDR_IRQ_MASK, 32'h0);
    wt(3);
    `CHK(irq, 1'h0)
    apb(1'h1, ADDR_IRQ_MASK, 32'h1f);
    apb(1'h1, ADDR_IRQ_STAT, 32'h4);
    wt(3);
    `CHK(irq, 1'h0)
    fan_slow <= 1'h0;
    wt(6);
    `CHK(alarm, 1'h0)
  endtask
  task automatic t_inrush;
    pulses(IN_PER * 90 - 1, 1'b0);
    rdchk(ADDR_INRUSH, 32'hb);
    `CHK(alarm, 1'h0)
    pulses(1, 1'b0);
    rdchk(ADDR_BITMAP, 32'h8);
    `CHK(alarm, 1'h1)
    `CHK(w_inr, 1'h1)
    pulses(IN_PER * 12, 1'b0);
    rdchk(ADDR_INRUSH, 32'h0);
  endtask
  task automatic t_ctrl;
    temp_w <= 4'h4;
    pulses(180, 1'b1);
    rdchk(ADDR_CTRL, 32'ha);
    rdchk(ADDR_BITMAP, 32'h8);
    pulses(2, 1'b1);
    rdchk(ADDR_BITMAP, 32'h9);
    `CHK(w_ctrl, 1'h1)
    pulses(24, 1'b1);
    rdchk(ADDR_CTRL, 32'h0);
  endtask
  // Kinds: 0 good, 1 bad result, 2 trip, 3 run, 4 shutoff, 5 power back,
  // 6 trip and run together.
  task automatic meas(input int kind, input logic [3:0] e);
    int n;
    n = 0;
    // The motor counts as connected and at rest, so run stays low here.
    apb(1'h1, ADDR_MEAS, 32'h1);
    cap_ok <= (kind != 1);
    cap_pct <= MAIN_ALARM_PCT;
    pwr_off <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i == 0) `CHK(dc, 1'h0)
      // This clear lands on the completing edge and must lose to the event.
      if (kind == 0 && i == 13) begin
        fork
          apb(1'h1, ADDR_IRQ_STAT, 32'h10);
        join_none
      end
      if (i == 4) begin
        `CHK(dc, 1'h1)
        trip <= (kind == 2 || kind == 6);
        run <= (kind == 3 || kind == 6);
        shut <= (kind == 4);
        if (kind == 5) pwr_off <= 1'h0;
      end
      if (dc === 1'h1) n++;
    end
    trip <= 1'h0;
    run <= 1'h0;
    shut <= 1'h0;
    pwr_off <= 1'h0;
    wt(3);
    rdchk(ADDR_MEAS, {28'h0, e});
    if (kind < 2) `CHK(n, DC_N)
  endtask
  task automatic t_meas;
    meas(0, MS_DONE);
    rdchk(ADDR_MAIN, {25'h0, MAIN_ALARM_PCT});
    rdchk(ADDR_BITMAP, 32'hb);
    `CHK(w_main, 1'h1)
    apb(1'h0, ADDR_IRQ_STAT, 32'h0);
    `CHK(rd[IRQ_MEAS_END], 1'h1)
    meas(1, MS_ERROR);
    meas(2, MS_ERROR);
    meas(3, MS_FORCED);
    meas(4, MS_FORCED);
    meas(6, MS_ERROR);
    meas(5, MS_ARMED);
    apb(1'h1, ADDR_MEAS, 32'h0);
    rdchk(ADDR_MEAS, {28'h0, MS_IDLE});
  endtask
  initial begin
    rst_b = 1'h0;
    {psel, penable, pwrite, inrush, age, fan_slow} = 6'h0;
    {pwr_off, run, shut, trip, cap_ok, act_low} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    temp_w = 4'h1;
    cap_pct = 7'h0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    wt(2);
    rst_b <= 1'h1;
    t_reset;
    t_fan;
    t_inrush;
    t_ctrl;
    t_meas;
    test_done;
  end
endmodule
`default_nettype wire
